// file: src/zc_alert_output.sv
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ps

// What this block does
// - Two-bit edge code per channel: ch 5 in bits 3-2, ch 4 in bits 1-0.
// - Code 00 drives 0 on both crossings, code 11 drives 1 on both.
// - Code 01 drives low on rising and high on falling crossing.
// - Code 10 drives high on rising and low on falling crossing.
// - Crossing-enabled outputs update on their crossings via the edge code.
// - Crossings leave an output alone while its crossing enable is 0.
// - Alert-enabled outputs update when selected alert flags become set.
// - Alert flags leave an output alone while its alert enable is 0.
// - Alert update drives each affected output to its trigger value bit.
// - Crossing enable, alert enable and trigger value reset to zero.
// - Each pin is analog, digital input, open-drain or push-pull output.
// - Digital input levels are readable through the input value register.
// - Open-drain pulls low only when driving 0, otherwise releases the pin.
// - Each output has a byte choosing which channels' alerts trigger it.
// - Channels 0 to 3 selectors sit in a separate byte resetting to zero.
// - Upper selector byte resets to zero, channel 7 bits 7-6, 6 bits 5-4.
module zc_alert_output (
    input  wire logic                                     ref_clk,
    input  wire logic                                     srst,
    input  wire logic [zc_alert_output_pkg::ADDR_W-1:0]   addr,
    input  wire logic [zc_alert_output_pkg::DATA_W-1:0]   wdata,
    input  wire logic                                     wr_en,
    input  wire logic                                     rd_en,
    output logic      [zc_alert_output_pkg::DATA_W-1:0]   rdata,
    input  wire logic [zc_alert_output_pkg::CH_COUNT-1:0] zero_cross_indication,
    input  wire logic [zc_alert_output_pkg::CH_COUNT-1:0] alert_flags,
    input  wire logic [zc_alert_output_pkg::CH_COUNT-1:0] channel_pin_in,
    output logic      [zc_alert_output_pkg::CH_COUNT-1:0] channel_pin_out,
    output logic      [zc_alert_output_pkg::CH_COUNT-1:0] channel_pin_oe_n
);
    import zc_alert_output_pkg::*;

    // -------------------------------------------------------------------
    // State
    // -------------------------------------------------------------------
    typedef struct packed {
        logic [CH_COUNT-1:0]          pin_digital;
        logic [CH_COUNT-1:0]          io_output;
        logic [CH_COUNT-1:0]          drive_push;
        logic [CH_COUNT-1:0]          digital_output;
        logic [CH_COUNT-1:0]          pin_sample;
        logic [CH_COUNT-1:0]          zc_prev;
        logic [CH_COUNT-1:0]          alert_prev;
        logic [CH_COUNT-1:0][DATA_W-1:0] alert_source_select;
        logic [DATA_W-1:0]            edge_sel_lo;
        logic [DATA_W-1:0]            edge_sel_hi;
        logic [CH_COUNT-1:0]          crossing_sync_enable;
        logic [CH_COUNT-1:0]          alert_update_enable;
        logic [CH_COUNT-1:0]          alert_update_value;
        logic [DATA_W-1:0]            rdata;
    } state_type;

    state_type state;
    state_type next_state;

    logic [CH_COUNT-1:0] is_dig_out;
    logic [CH_COUNT-1:0] rise;
    logic [CH_COUNT-1:0] fall;
    logic [CH_COUNT-1:0] alert_new;
    logic [CH_COUNT-1:0] alert_hit;
    logic [CH_COUNT-1:0] cross_hit;
    logic [CH_COUNT-1:0] input_level_value;

    // Pick one channel's two-bit edge code out of the two selector bytes.
    function automatic logic [SEL_W-1:0] edge_code(
        input logic [DATA_W-1:0] lo,
        input logic [DATA_W-1:0] hi,
        input int unsigned       ch
    );
        logic [2*DATA_W-1:0] both;
        both = {hi, lo};
        edge_code = both[ch*SEL_W +: SEL_W];
    endfunction

    // -------------------------------------------------------------------
    // Event detection
    // -------------------------------------------------------------------
    // Edges are found against last cycle's sample, so a level held high
    // triggers only once; software must not expect repeated updates.
    assign is_dig_out = state.pin_digital & state.io_output;
    assign rise       = zero_cross_indication & ~state.zc_prev;
    assign fall       = ~zero_cross_indication & state.zc_prev;
    assign alert_new  = alert_flags & ~state.alert_prev;
    assign input_level_value = state.pin_sample & state.pin_digital
                             & ~state.io_output;

    // Per output: which events reach it.
    genvar g;
    generate
        for (g = 0; g < CH_COUNT; g++) begin : gen_hit
            // An output reacts only to alerts of the channels it selects.
            assign alert_hit[g] = state.alert_update_enable[g]
                & |(alert_new & state.alert_source_select[g]);
            assign cross_hit[g] = state.crossing_sync_enable[g]
                & (rise[g] | fall[g]);
        end
    endgenerate

    // -------------------------------------------------------------------
    // Next state
    // -------------------------------------------------------------------
    // Priority per output bit: alert update, then crossing, then a plain
    // software write; all three can land in the same cycle.
    always_comb begin
        logic [SEL_W-1:0] code;
        code = CODE_ZERO;
        next_state = state;
        next_state.zc_prev    = zero_cross_indication;
        next_state.alert_prev = alert_flags;
        next_state.pin_sample = channel_pin_in;
        next_state.rdata      = RESET_BYTE;
        if (wr_en) begin
            case (addr)
                ADDR_PIN_DIGITAL: next_state.pin_digital = wdata;
                ADDR_IO_OUTPUT:   next_state.io_output = wdata;
                ADDR_DRIVE_PUSH:  next_state.drive_push = wdata;
                ADDR_OUT_VALUE:   next_state.digital_output = wdata;
                ADDR_EDGE_SEL_LO: next_state.edge_sel_lo = wdata;
                ADDR_EDGE_SEL_HI: next_state.edge_sel_hi = wdata;
                ADDR_CROSS_EN:    next_state.crossing_sync_enable = wdata;
                ADDR_ALERT_EN:    next_state.alert_update_enable = wdata;
                ADDR_ALERT_VALUE: next_state.alert_update_value = wdata;
                default: ;
            endcase
            for (int i = 0; i < CH_COUNT; i++) begin
                if (addr == ADDR_SRC_SEL_BASE
                        + 8'(i) * ADDR_SRC_SEL_STEP) begin
                    next_state.alert_source_select[i] = wdata;
                end
            end
        end
        for (int i = 0; i < CH_COUNT; i++) begin
            code = edge_code(state.edge_sel_lo, state.edge_sel_hi, i);
            if (is_dig_out[i]) begin
                if (alert_hit[i]) begin
                    next_state.digital_output[i] =
                        state.alert_update_value[i];
                end else if (cross_hit[i]) begin
                    // Rising takes the high code bit, falling the low one.
                    next_state.digital_output[i] = rise[i]
                        ? code[RISE_BIT]
                        : code[FALL_BIT];
                end
            end
        end
        if (rd_en) begin
            case (addr)
                ADDR_PIN_DIGITAL: next_state.rdata = state.pin_digital;
                ADDR_IO_OUTPUT:   next_state.rdata = state.io_output;
                ADDR_DRIVE_PUSH:  next_state.rdata = state.drive_push;
                ADDR_OUT_VALUE:   next_state.rdata = state.digital_output;
                ADDR_INPUT_LEVEL: next_state.rdata = input_level_value;
                ADDR_EDGE_SEL_LO: next_state.rdata = state.edge_sel_lo;
                ADDR_EDGE_SEL_HI: next_state.rdata = state.edge_sel_hi;
                ADDR_CROSS_EN:
                    next_state.rdata = state.crossing_sync_enable;
                ADDR_ALERT_EN:
                    next_state.rdata = state.alert_update_enable;
                ADDR_ALERT_VALUE:
                    next_state.rdata = state.alert_update_value;
                default: next_state.rdata = RESET_BYTE;
            endcase
            for (int i = 0; i < CH_COUNT; i++) begin
                if (addr == ADDR_SRC_SEL_BASE
                        + 8'(i) * ADDR_SRC_SEL_STEP) begin
                    next_state.rdata = state.alert_source_select[i];
                end
            end
        end
        if (srst) begin
            next_state = '0;
        end
    end

    // Register the whole state.
    always_ff @(posedge ref_clk) begin
        state <= next_state;
    end

    // -------------------------------------------------------------------
    // Pin drivers
    // -------------------------------------------------------------------
    // Open-drain never drives a high level, so an external pull-up can sit
    // at a voltage above the core supply without fighting the driver.
    always_comb begin
        for (int i = 0; i < CH_COUNT; i++) begin
            if (is_dig_out[i] && state.drive_push[i]) begin
                channel_pin_out[i]  = state.digital_output[i];
                channel_pin_oe_n[i] = 1'b0;
            end else if (is_dig_out[i]) begin
                channel_pin_out[i]  = 1'b0;
                channel_pin_oe_n[i] = state.digital_output[i];
            end else begin
                channel_pin_out[i]  = 1'b0;
                channel_pin_oe_n[i] = 1'b1;
            end
        end
    end

    assign rdata = state.rdata;

    // -------------------------------------------------------------------
    // Assertions
    // -------------------------------------------------------------------
    property p_reset_clear;
        @(posedge ref_clk) srst |=> state.crossing_sync_enable == 8'h00
            && state.alert_update_enable == 8'h00
            && state.alert_update_value == 8'h00
            && state.edge_sel_hi == 8'h00 && state.edge_sel_lo == 8'h00;
    endproperty
    a_reset_clear: assert property (p_reset_clear)
        else $error("Configuration not zero after reset.");

    property p_code_one_ch4;
        @(posedge ref_clk) disable iff (srst)
        (is_dig_out[4] && cross_hit[4] && !alert_hit[4]
            && state.edge_sel_hi[1:0] == CODE_ONE)
            |=> state.digital_output[4];
    endproperty
    a_code_one_ch4: assert property (p_code_one_ch4)
        else $error("Code 11 did not drive channel 4 high.");

    property p_code_zero_ch4;
        @(posedge ref_clk) disable iff (srst)
        (is_dig_out[4] && cross_hit[4] && !alert_hit[4]
            && state.edge_sel_hi[1:0] == CODE_ZERO)
            |=> !state.digital_output[4];
    endproperty
    a_code_zero_ch4: assert property (p_code_zero_ch4)
        else $error("Code 00 did not drive channel 4 low.");

    property p_invert_ch5;
        @(posedge ref_clk) disable iff (srst)
        (is_dig_out[5] && cross_hit[5] && !alert_hit[5]
            && state.edge_sel_hi[3:2] == CODE_INVERT)
            |=> state.digital_output[5] == $past(fall[5]);
    endproperty
    a_invert_ch5: assert property (p_invert_ch5)
        else $error("Code 01 did not invert the crossing on channel 5.");

    property p_follow_ch5;
        @(posedge ref_clk) disable iff (srst)
        (is_dig_out[5] && cross_hit[5] && !alert_hit[5]
            && state.edge_sel_hi[3:2] == CODE_FOLLOW)
            |=> state.digital_output[5] == $past(rise[5]);
    endproperty
    a_follow_ch5: assert property (p_follow_ch5)
        else $error("Code 10 did not follow the crossing on channel 5.");

    property p_quiet_hold;
        @(posedge ref_clk) disable iff (srst)
        (!wr_en && alert_hit == 8'h00 && cross_hit == 8'h00)
            |=> $stable(state.digital_output);
    endproperty
    a_quiet_hold: assert property (p_quiet_hold)
        else $error("Output changed with no enabled event.");

    property p_alert_value;
        @(posedge ref_clk) disable iff (srst)
        (is_dig_out[2] && alert_hit[2])
            |=> state.digital_output[2] == $past(state.alert_update_value[2]);
    endproperty
    a_alert_value: assert property (p_alert_value)
        else $error("Alert update did not load the trigger value.");

    property p_open_drain;
        @(posedge ref_clk) disable iff (srst)
        (is_dig_out[3] && !state.drive_push[3])
            |-> !channel_pin_out[3]
            && channel_pin_oe_n[3] == state.digital_output[3];
    endproperty
    a_open_drain: assert property (p_open_drain)
        else $error("Open-drain pin drove high or released while low.");

    property p_not_output_released;
        @(posedge ref_clk) disable iff (srst)
        (!is_dig_out[0] && !wr_en)
            |=> channel_pin_oe_n[0] && $stable(state.digital_output[0]);
    endproperty
    a_not_output_released: assert property (p_not_output_released)
        else $error("Non-output pin was driven.");

    property p_input_read;
        @(posedge ref_clk) disable iff (srst)
        (rd_en && addr == ADDR_INPUT_LEVEL && state.pin_digital[6]
            && !state.io_output[6])
            |=> rdata[6] == $past(channel_pin_in[6], 2);
    endproperty
    a_input_read: assert property (p_input_read)
        else $error("Input level read back wrong.");

endmodule

// file: src/zc_alert_output_pkg.sv
package zc_alert_output_pkg;

    // -------------------------------------------------------------------
    // Geometry and field layout
    // -------------------------------------------------------------------
    localparam int unsigned ADDR_W   = 8;
    localparam int unsigned DATA_W   = 8;
    localparam int unsigned CH_COUNT = 8;
    localparam int unsigned SEL_W    = 2;  // Edge value code per channel.
    localparam int unsigned SEL_PER_BYTE = 4;
    localparam int unsigned RISE_BIT = 1;  // Code bit used on a rising edge.
    localparam int unsigned FALL_BIT = 0;  // Code bit used on a falling edge.

    // -------------------------------------------------------------------
    // Register offsets
    // -------------------------------------------------------------------
    localparam logic [7:0] ADDR_PIN_DIGITAL  = 8'h01;
    localparam logic [7:0] ADDR_IO_OUTPUT    = 8'h03;
    localparam logic [7:0] ADDR_DRIVE_PUSH   = 8'h05;
    localparam logic [7:0] ADDR_OUT_VALUE    = 8'h07;
    localparam logic [7:0] ADDR_INPUT_LEVEL  = 8'h09;
    localparam logic [7:0] ADDR_SRC_SEL_BASE = 8'hC3;  // Output 0 selector.
    localparam logic [7:0] ADDR_SRC_SEL_STEP = 8'h02;  // Output 7 at 0xD1.
    localparam logic [7:0] ADDR_EDGE_SEL_LO  = 8'hE3;
    localparam logic [7:0] ADDR_EDGE_SEL_HI  = 8'hE4;
    localparam logic [7:0] ADDR_CROSS_EN     = 8'hE7;
    localparam logic [7:0] ADDR_ALERT_EN     = 8'hE9;
    localparam logic [7:0] ADDR_ALERT_VALUE  = 8'hEB;

    // -------------------------------------------------------------------
    // Reset values
    // -------------------------------------------------------------------
    localparam logic [7:0] RESET_BYTE = 8'h00;

    // Edge value codes.
    localparam logic [1:0] CODE_ZERO   = 2'h0;
    localparam logic [1:0] CODE_INVERT = 2'h1;
    localparam logic [1:0] CODE_FOLLOW = 2'h2;
    localparam logic [1:0] CODE_ONE    = 2'h3;

endpackage

// file: test/pin_board.sv
`timescale 1ns/1ps

// ---------------------------------------------------------------
// Board circuit on the eight channel pins
// ---------------------------------------------------------------
module pin_board (
    input  wire logic [7:0] pin_out,
    input  wire logic [7:0] pin_oe_n,
    input  wire logic [7:0] ext_drive,
    input  wire logic [7:0] ext_level,
    output logic      [7:0] pin_level
);
    // Every pin carries a pull-up, so a released line nobody drives reads 1.
    // The board never drives against an enabled device driver.
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (!pin_oe_n[i]) begin
                pin_level[i] = pin_out[i];
            end else if (ext_drive[i]) begin
                pin_level[i] = ext_level[i];
            end else begin
                pin_level[i] = 1'b1;
            end
        end
    end
endmodule

// file: test/testbench.sv
`timescale 1ns/1ps

module testbench;
    import zc_alert_output_pkg::*;

    logic        ref_clk;
    logic        srst;
    logic [7:0]  addr;
    logic [7:0]  wdata;
    logic        wr_en;
    logic        rd_en;
    logic [7:0]  rdata;
    logic [7:0]  zc;
    logic [7:0]  alert;
    logic [7:0]  pin_in;
    logic [7:0]  pin_out;
    logic [7:0]  oe_n;
    logic [7:0]  ext_drive;
    logic [7:0]  ext_level;
    int          n_mismatch;
    int          compares;

    zc_alert_output i_dut (.ref_clk(ref_clk), .srst(srst), .addr(addr),
        .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
        .zero_cross_indication(zc), .alert_flags(alert),
        .channel_pin_in(pin_in), .channel_pin_out(pin_out),
        .channel_pin_oe_n(oe_n));

    pin_board i_board (.pin_out(pin_out), .pin_oe_n(oe_n),
        .ext_drive(ext_drive), .ext_level(ext_level), .pin_level(pin_in));

    // ---------------------------------------------------------------
    // Compares, bus cycles and event stimulus
    // ---------------------------------------------------------------
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_pin(input logic got, input logic exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        addr  <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge ref_clk);
        wr_en <= 1'b0;
        #1;
    endtask

    // Read data stand only in the cycle after the strobe, so sample there.
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge ref_clk);
        addr  <= a;
        rd_en <= 1'b1;
        @(posedge ref_clk);
        rd_en <= 1'b0;
        #1 chk_byte(rdata, exp);
    endtask

    // The event edge lands one edge later; the pin is checked right after.
    task automatic set_zc(input int ch, input logic lvl);
        @(posedge ref_clk);
        zc[ch] <= lvl;
        @(posedge ref_clk);
        #1;
    endtask

    task automatic set_alert(input int ch, input logic lvl);
        @(posedge ref_clk);
        alert[ch] <= lvl;
        @(posedge ref_clk);
        #1;
    endtask

    task automatic end_of_test();
        if (n_mismatch == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // ---------------------------------------------------------------
    // Scenarios
    // ---------------------------------------------------------------
    task automatic t_reset();
        chk_byte(oe_n, 8'hFF);
        rd(ADDR_CROSS_EN, 8'h00);
        rd(ADDR_ALERT_EN, 8'h00);
        rd(ADDR_ALERT_VALUE, 8'h00);
        rd(ADDR_EDGE_SEL_LO, 8'h00);
        rd(ADDR_EDGE_SEL_HI, 8'h00);
        rd(8'hD1, 8'h00);
    endtask

    // Unmapped and read-only places must ignore writes while all pins are analog; then pin modes are set.
    task automatic t_regs();
        wr(ADDR_EDGE_SEL_HI, 8'h5A);
        rd(ADDR_EDGE_SEL_HI, 8'h5A);
        wr(8'h20, 8'hFF);
        rd(8'h20, 8'h00);
        wr(ADDR_INPUT_LEVEL, 8'hFF);
        rd(ADDR_INPUT_LEVEL, 8'h00);
        wr(ADDR_PIN_DIGITAL, 8'hFF);
        wr(ADDR_IO_OUTPUT, 8'hBF);
        wr(ADDR_DRIVE_PUSH, 8'hF7);
    endtask

    // Channel n uses code n mod 4; channel 6 is skipped, so the loop sees code 10 in the low byte only and channel 5 takes it after.
    task automatic t_cross();
        logic [1:0] code;
        wr(ADDR_CROSS_EN, 8'hFF);
        wr(ADDR_EDGE_SEL_LO, 8'hE4);
        wr(ADDR_EDGE_SEL_HI, 8'hE4);
        for (int ch = 0; ch < 8; ch++) begin
            code = 2'(ch % 4);
            if (ch != 6) begin
                wr(ADDR_OUT_VALUE, code[1] ? 8'h00 : 8'hFF);
                set_zc(ch, 1'b1);
                chk_pin(pin_in[ch], code[1]);
                set_zc(ch, 1'b0);
                chk_pin(pin_in[ch], code[0]);
            end
        end
        // Code 11 on channel 4 and code 10 on channel 5 in one pass.
        wr(ADDR_EDGE_SEL_HI, 8'h0B);
        wr(ADDR_OUT_VALUE, 8'h00);
        set_zc(4, 1'b1);
        set_zc(5, 1'b1);
        chk_byte(pin_in & 8'h30, 8'h30);
        set_zc(4, 1'b0);
        set_zc(5, 1'b0);
        chk_byte(pin_in & 8'h30, 8'h10);
        wr(ADDR_CROSS_EN, 8'h00);
        wr(ADDR_OUT_VALUE, 8'hFF);
        set_zc(0, 1'b1);
        chk_pin(pin_in[0], 1'b1);
        set_zc(0, 1'b0);
        chk_pin(pin_in[0], 1'b1);
    endtask

    task automatic t_alert();
        wr(8'hC7, 8'h10);
        rd(8'hC7, 8'h10);
        wr(ADDR_ALERT_VALUE, 8'h00);
        wr(ADDR_ALERT_EN, 8'h04);
        set_alert(5, 1'b1);
        chk_pin(pin_in[2], 1'b1);
        set_alert(4, 1'b1);
        chk_pin(pin_in[2], 1'b0);
        chk_pin(pin_in[1], 1'b1);
        set_alert(4, 1'b0);
        wr(ADDR_ALERT_EN, 8'h00);
        wr(ADDR_ALERT_VALUE, 8'h04);
        set_alert(4, 1'b1);
        chk_pin(pin_in[2], 1'b0);
        set_alert(4, 1'b0);
        wr(ADDR_ALERT_EN, 8'h04);
        set_alert(4, 1'b1);
        chk_pin(pin_in[2], 1'b1);
        set_alert(4, 1'b0);
        set_alert(5, 1'b0);
    endtask

    task automatic t_modes();
        wr(ADDR_OUT_VALUE, 8'hFF);
        chk_byte(oe_n, 8'h48);
        chk_pin(pin_in[3], 1'b1);
        wr(ADDR_OUT_VALUE, 8'hF7);
        chk_pin(oe_n[3], 1'b0);
        chk_pin(pin_in[3], 1'b0);
        rd(ADDR_INPUT_LEVEL, 8'h40);
        @(posedge ref_clk);
        ext_level <= 8'h00;
        repeat (3) @(posedge ref_clk);
        rd(ADDR_INPUT_LEVEL, 8'h00);
    endtask

    task automatic t_analog();
        wr(ADDR_PIN_DIGITAL, 8'hFE);
        // Code 00 would clear the stored bit if an analog pin took events.
        wr(ADDR_EDGE_SEL_LO, 8'h00);
        wr(ADDR_CROSS_EN, 8'h01);
        set_zc(0, 1'b1);
        chk_pin(oe_n[0], 1'b1);
        rd(ADDR_OUT_VALUE, 8'hF7);
        set_zc(0, 1'b0);
    endtask

    // Free-running 100 MHz clock.
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    // The run needs under two hundred cycles; 10000 cycles means a hang.
    initial begin
        #100000;
        n_mismatch++;
        end_of_test();
    end

    // Main sequence: reset for two cycles, then every scenario in turn.
    initial begin
        n_mismatch = 0;
        compares   = 0;
        srst       = 1'b1;
        addr       = 8'h00;
        wdata      = 8'h00;
        wr_en      = 1'b0;
        rd_en      = 1'b0;
        zc         = 8'h00;
        alert      = 8'h00;
        ext_drive  = 8'h40;
        ext_level  = 8'h40;
        repeat (2) @(posedge ref_clk);
        srst <= 1'b0;
        @(posedge ref_clk);
        #1;
        t_reset();
        t_regs();
        t_cross();
        t_alert();
        t_modes();
        t_analog();
        end_of_test();
    end
endmodule
